// file: psi_host_end.sv
/*
 Host end: AXI4-Lite register slave for software that forwards orders to
 the device over the link, mirrors its status and raises an interrupt.
 Assumes the device answers link reads one cycle after the request.
*/
// Chosen here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module psi_host_end
   import psi_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        rst,
   psi_link_if.host         lnk,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             irq
);
   logic [8:0]  cmd_ff;
   logic [1:0]  relay_ff;
   logic [5:0]  pat_ff;
   logic [6:0]  seq_ff;
   logic [11:0] res_ff;
   logic [1:0]  irqStat_ff;
   logic [1:0]  irqMask_ff;
   logic        irq_ff;
   logic [3:0]  pend_ff;
   logic        rdSel_ff;
   logic [3:0]  rdTag_ff;
   logic        lwr_ff;
   logic        lrd_ff;
   logic [3:0]  laddr_ff;
   logic [15:0] lwdata_ff;
   logic        awHave_ff;
   logic        wHave_ff;
   logic [7:0]  awAddr_ff;
   logic [31:0] wData_ff;
   logic [3:0]  wStrb_ff;
   logic        awready_ff;
   logic        wready_ff;
   logic        bvalid_ff;
   logic [1:0]  bresp_ff;
   logic        arready_ff;
   logic        rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0]  rresp_ff;
   logic        doWr;
   logic        doRd;
   logic [31:0] wm;
   logic [1:0]  events;

   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                         input logic [3:0] s);
      logic [31:0] r;
      r = o;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            r[8*i +: 8] = d[8*i +: 8];
         end
      end
      return r;
   endfunction

   assign doWr = awHave_ff && wHave_ff && !bvalid_ff;
   assign doRd = s_axi_arvalid && arready_ff;
   assign wm   = merge(32'h0, wData_ff, wStrb_ff);
   assign events[IRQ_DONE] = lnk.rvalid && rdTag_ff == REG_SEQ && seq_ff[SQ_AUTO] && !lnk.rdata[SQ_AUTO];
   assign events[IRQ_ERR]  = lnk.rvalid && rdTag_ff == REG_SEQ && !seq_ff[SQ_ERR] && lnk.rdata[SQ_ERR];

   // AXI write channels, taken in either order
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         awHave_ff  <= 1'b0;
         wHave_ff   <= 1'b0;
         awAddr_ff  <= 8'h00;
         wData_ff   <= 32'h0;
         wStrb_ff   <= 4'h0;
         awready_ff <= 1'b0;
         wready_ff  <= 1'b0;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= 2'h0;
      end else begin
         if (s_axi_awvalid && awready_ff) begin
            awHave_ff <= 1'b1;
            awAddr_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid && wready_ff) begin
            wHave_ff <= 1'b1;
            wData_ff <= s_axi_wdata;
            wStrb_ff <= s_axi_wstrb;
         end
         awready_ff <= !awHave_ff && !(s_axi_awvalid && awready_ff) && !doWr && !bvalid_ff;
         wready_ff  <= !wHave_ff && !(s_axi_wvalid && wready_ff) && !doWr && !bvalid_ff;
         if (doWr) begin
            awHave_ff <= 1'b0;
            wHave_ff  <= 1'b0;
            bvalid_ff <= 1'b1;
            bresp_ff  <= (awAddr_ff == H_CMD || awAddr_ff == H_RELAY || awAddr_ff == H_PAT
                          || awAddr_ff == H_IRQ_MASK) ? 2'h0 : 2'h2;
         end else if (bvalid_ff && s_axi_bready) begin
            bvalid_ff <= 1'b0;
         end
      end
   end

   // command registers and link write sequencing
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cmd_ff     <= 9'h000;
         relay_ff   <= RELAY_RST;
         pat_ff     <= 6'h00;
         irqMask_ff <= 2'h0;
         pend_ff    <= 4'h0;
         rdSel_ff   <= 1'b0;
         lwr_ff     <= 1'b0;
         lrd_ff     <= 1'b0;
         laddr_ff   <= 4'h0;
         lwdata_ff  <= 16'h0000;
      end else begin
         lwr_ff <= 1'b0;
         lrd_ff <= 1'b0;
         // unlock reaches the device before the start write
         if (pend_ff[0]) begin
            lwr_ff    <= 1'b1;
            laddr_ff  <= REG_CNT2;
            lwdata_ff <= {15'h0000, cmd_ff[HC_UNLOCK]};
            pend_ff[0] <= 1'b0;
         end else if (pend_ff[1]) begin
            lwr_ff    <= 1'b1;
            laddr_ff  <= REG_CNT1;
            lwdata_ff <= {8'h00, cmd_ff[7:0]};
            pend_ff[1] <= 1'b0;
            cmd_ff[C1_START] <= 1'b0;
         end else if (pend_ff[2]) begin
            lwr_ff    <= 1'b1;
            laddr_ff  <= REG_RELAY;
            lwdata_ff <= {14'h0000, relay_ff};
            pend_ff[2] <= 1'b0;
         end else if (pend_ff[3]) begin
            lwr_ff    <= 1'b1;
            laddr_ff  <= REG_PAT;
            lwdata_ff <= {10'h000, pat_ff};
            pend_ff[3] <= 1'b0;
         end else begin
            // status polling alternates sequence and result
            lrd_ff   <= 1'b1;
            laddr_ff <= rdSel_ff ? REG_RES : REG_SEQ;
            rdSel_ff <= !rdSel_ff;
         end
         if (doWr) begin
            unique case (awAddr_ff)
               H_CMD: begin
                  cmd_ff  <= 9'(merge({23'h0, cmd_ff}, wm, wStrb_ff));
                  pend_ff[1:0] <= 2'h3;
               end
               H_RELAY: begin
                  relay_ff   <= wm[1:0];
                  pend_ff[2] <= 1'b1;
               end
               H_PAT: begin
                  pat_ff     <= wm[5:0];
                  pend_ff[3] <= 1'b1;
               end
               H_IRQ_MASK: irqMask_ff <= wm[1:0];
               default: ;
            endcase
         end
      end
   end

   // device status mirror and interrupt
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rdTag_ff   <= 4'h0;
         seq_ff     <= 7'h00;
         res_ff     <= 12'h000;
         irqStat_ff <= 2'h0;
         irq_ff     <= 1'b0;
      end else begin
         rdTag_ff <= laddr_ff;
         if (lnk.rvalid && rdTag_ff == REG_SEQ) begin
            seq_ff <= lnk.rdata[6:0];
         end
         if (lnk.rvalid && rdTag_ff == REG_RES) begin
            res_ff <= lnk.rdata[11:0];
         end
         // a new event wins over the clearing read
         irqStat_ff <= ((doRd && s_axi_araddr == H_IRQ_STAT) ? 2'h0 : irqStat_ff) | events;
         irq_ff     <= |((((doRd && s_axi_araddr == H_IRQ_STAT) ? 2'h0 : irqStat_ff) | events) & irqMask_ff);
      end
   end

   // AXI read channel
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         arready_ff <= 1'b0;
         rvalid_ff  <= 1'b0;
         rdata_ff   <= 32'h0;
         rresp_ff   <= 2'h0;
      end else begin
         arready_ff <= !rvalid_ff && !doRd;
         if (doRd) begin
            rvalid_ff <= 1'b1;
            rresp_ff  <= 2'h0;
            unique case (s_axi_araddr)
               H_CMD: rdata_ff <= {23'h0, cmd_ff};
               H_RELAY: rdata_ff <= {30'h0, relay_ff};
               H_PAT: rdata_ff <= {26'h0, pat_ff};
               H_STAT: rdata_ff <= {25'h0, seq_ff};
               H_RES: rdata_ff <= {20'h0, res_ff};
               H_IRQ_STAT: rdata_ff <= {30'h0, irqStat_ff};
               H_IRQ_MASK: rdata_ff <= {30'h0, irqMask_ff};
               default: begin
                  rdata_ff <= 32'h0;
                  rresp_ff <= 2'h2;
               end
            endcase
         end else if (rvalid_ff && s_axi_rready) begin
            rvalid_ff <= 1'b0;
         end
      end
   end

   assign lnk.wr        = lwr_ff;
   assign lnk.rd        = lrd_ff;
   assign lnk.addr      = laddr_ff;
   assign lnk.wdata     = lwdata_ff;
   assign s_axi_awready = awready_ff;
   assign s_axi_wready  = wready_ff;
   assign s_axi_bvalid  = bvalid_ff;
   assign s_axi_bresp   = bresp_ff;
   assign s_axi_arready = arready_ff;
   assign s_axi_rvalid  = rvalid_ff;
   assign s_axi_rdata   = rdata_ff;
   assign s_axi_rresp   = rresp_ff;
   assign irq           = irq_ff;
endmodule // psi_host_end
`default_nettype wire

// file: psi_pkg.sv
/*
 Shared constants, types and helpers for the power switch inspection mode
 controller: device register indices, field positions, timing counts.
 Assumes a 200 MHz system clock and a synchronous active-high reset.
*/
`default_nettype none
package psi_pkg;
   localparam int CLK_NS     = 5;
   localparam int SETTLE_NS  = 10000;
   localparam int STEP_NS    = 2000;
   localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
   localparam int STEP_CYC   = (STEP_NS + CLK_NS - 1) / CLK_NS;
   localparam int CNT_W      = 12;
   localparam logic [2:0] LAST_STEP = 3'h6;

   // device register indices on the link
   localparam logic [3:0] REG_CNT1  = 4'h0;
   localparam logic [3:0] REG_CNT2  = 4'h1;
   localparam logic [3:0] REG_RELAY = 4'h2;
   localparam logic [3:0] REG_PAT   = 4'h3;
   localparam logic [3:0] REG_RES   = 4'h4;
   localparam logic [3:0] REG_SEQ   = 4'h5;

   // CNT1, CNT2 / host command fields
   localparam int C1_MANUAL = 0;
   localparam int C1_START  = 1;
   localparam int C1_TYPE   = 2;
   localparam int C1_MIDON  = 4;
   localparam int C1_VIEW   = 7;
   localparam int C2_UNLOCK = 0;
   localparam int HC_UNLOCK = 8;
   // SEQ status fields and relay reset value
   localparam int SQ_AUTO = 0;
   localparam int SQ_ERR  = 1;
   localparam int SQ_NUM  = 4;
   localparam logic [1:0] RELAY_RST = 2'h0;

   // host AXI4-Lite byte offsets and interrupt bits
   localparam logic [7:0] H_CMD      = 8'h00;
   localparam logic [7:0] H_RELAY    = 8'h04;
   localparam logic [7:0] H_PAT      = 8'h08;
   localparam logic [7:0] H_STAT     = 8'h0c;
   localparam logic [7:0] H_RES      = 8'h10;
   localparam logic [7:0] H_IRQ_STAT = 8'h14;
   localparam logic [7:0] H_IRQ_MASK = 8'h18;
   localparam int IRQ_DONE = 0;
   localparam int IRQ_ERR  = 1;

   typedef enum logic [1:0] {
      TYPE_A = 2'b00,
      TYPE_B = 2'b01,
      TYPE_C = 2'b10,
      TYPE_D = 2'b11
   } psi_type_t;

   typedef enum logic [1:0] {
      SQ_IDLE   = 2'b00,
      SQ_SETTLE = 2'b01,
      SQ_STEP   = 2'b10
   } psi_seq_t;

   // places {uh,ul,vh,vl,wh,wl} on the even bits D10..D0
   function automatic logic [11:0] psi_spread(input logic [5:0] v);
      logic [11:0] r;
      r = 12'h000;
      for (int i = 0; i < 6; i++) begin
         r[2*i] = v[i];
      end
      return r;
   endfunction
endpackage
`default_nettype wire

// file: psi_link_if.sv
/*
 Register link between the host controller and the inspection device.
 Host writes or reads one register per cycle; the device answers a read
 with rdata and rvalid exactly one cycle later.
*/
`timescale 1ns/10ps
`default_nettype none
interface psi_link_if;
   logic        wr;
   logic        rd;
   logic [3:0]  addr;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic        rvalid;

   modport dev  (input wr, rd, addr, wdata, output rdata, rvalid);
   modport host (output wr, rd, addr, wdata, input rdata, rvalid);
endinterface
`default_nettype wire

// file: psi_dev_end.sv
/*
 Device end: inspection mode logic of the gate pre-driver. Routes the
 drain-source comparators, drives mid-voltage resistors, runs the automatic
 sequence. Assumes gate inputs, permits and comparators synchronous to sys_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module psi_dev_end
   import psi_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       rst,
   psi_link_if.dev         lnk,
   input  wire logic [5:0] gateIn,
   input  wire logic [2:0] gateEn,
   input  wire logic [5:0] vdsCmp,
   output logic      [5:0] gateOut,
   output logic      [1:0] relayDrv,
   output logic            midvResOnU,
   output logic            midvResOnV,
   output logic            midvResOnW,
   output logic            vdsDetEn,
   output logic            vdsFault
);
   logic            unlock_ff;
   logic            manual_ff;
   psi_type_t       type_ff;
   logic [2:0]      midon_ff;
   logic            view_ff;
   logic [1:0]      relay_ff;
   logic [5:0]      pat_ff;
   logic            auto_ff;
   logic            err_ff;
   logic [2:0]      seqNum_ff;
   logic [5:0]      snap_ff;
   psi_seq_t        state_ff;
   logic [CNT_W-1:0] cnt_ff;
   logic [5:0]      prev_ff;
   logic [5:0]      filt_ff;
   logic [5:0]      gateOut_ff;
   logic [1:0]      relayDrv_ff;
   logic [2:0]      midv_ff;
   logic            vdsDetEn_ff;
   logic            vdsFault_ff;
   logic [15:0]     rdata_ff;
   logic            rvalid_ff;
   logic            wrCnt1;
   logic            unlockOff;
   logic            launch;
   logic            inspect;
   logic            manualAct;
   logic [5:0]      drive;
   logic [5:0]      permit;
   logic [5:0]      filtIn;

   // drive for one step: step 0 all off, then uh,vh,wh,ul,vl,wl one by one
   function automatic logic [5:0] stepDrive(input logic [2:0] s);
      logic [5:0] d;
      d = 6'h00;
      unique case (s)
         3'h1: d = 6'h20;
         3'h2: d = 6'h08;
         3'h3: d = 6'h02;
         3'h4: d = 6'h10;
         3'h5: d = 6'h04;
         3'h6: d = 6'h01;
         default: d = 6'h00;
      endcase
      return d;
   endfunction

   function automatic logic [5:0] expect6(input psi_type_t t, input logic [2:0] s);
      logic [5:0] e;
      e = 6'h3f;
      if (t == TYPE_B) begin
         if (s >= 3'h4) begin
            e = 6'h2a;
         end else if (s != 3'h0) begin
            e = 6'h15;
         end
      end else begin
         e = 6'h3f & ~stepDrive(s);
      end
      return e;
   endfunction

   assign wrCnt1 = lnk.wr && (lnk.addr == REG_CNT1);
   assign unlockOff = lnk.wr && (lnk.addr == REG_CNT2) && !lnk.wdata[C2_UNLOCK];
   assign launch = wrCnt1 && lnk.wdata[C1_START] && unlock_ff && !auto_ff;
   assign manualAct = unlock_ff && manual_ff && !auto_ff;
   assign inspect   = unlock_ff && (manual_ff || auto_ff);
   assign drive  = (type_ff == TYPE_D) ? pat_ff : stepDrive(seqNum_ff);
   assign permit = {{2{gateEn[2]}}, {2{gateEn[1]}}, {2{gateEn[0]}}};
   assign filtIn = inspect ? vdsCmp : (vdsCmp & gateIn);

   // control register writes
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         unlock_ff <= 1'b0;
         manual_ff <= 1'b0;
         type_ff   <= TYPE_A;
         midon_ff  <= 3'h0;
         view_ff   <= 1'b0;
         relay_ff  <= RELAY_RST;
         pat_ff    <= 6'h00;
      end else if (lnk.wr) begin
         unique case (lnk.addr)
            REG_CNT1: begin
               manual_ff <= lnk.wdata[C1_MANUAL];
               type_ff   <= psi_type_t'(lnk.wdata[C1_TYPE +: 2]);
               midon_ff  <= lnk.wdata[C1_MIDON +: 3];
               view_ff   <= lnk.wdata[C1_VIEW];
            end
            REG_CNT2: unlock_ff <= lnk.wdata[C2_UNLOCK];
            REG_RELAY: relay_ff <= lnk.wdata[1:0];
            REG_PAT: pat_ff <= lnk.wdata[5:0];
            default: ;
         endcase
      end
   end

   // two-sample agreement noise filter
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         prev_ff <= 6'h00;
         filt_ff <= 6'h00;
      end else begin
         prev_ff <= filtIn;
         for (int i = 0; i < 6; i++) begin
            if (prev_ff[i] == filtIn[i]) begin
               filt_ff[i] <= filtIn[i];
            end
         end
      end
   end

   // automatic inspection sequence
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_ff  <= SQ_IDLE;
         cnt_ff    <= '0;
         auto_ff   <= 1'b0;
         err_ff    <= 1'b0;
         seqNum_ff <= 3'h0;
         snap_ff   <= 6'h00;
      end else if (!unlock_ff || unlockOff) begin
         state_ff <= SQ_IDLE;
         auto_ff  <= 1'b0;
      end else begin
         unique case (state_ff)
            SQ_IDLE: begin
               if (launch) begin
                  auto_ff   <= 1'b1;
                  err_ff    <= 1'b0;
                  seqNum_ff <= 3'h0;
                  cnt_ff    <= CNT_W'(SETTLE_CYC - 1);
                  state_ff  <= SQ_SETTLE;
               end
            end
            SQ_SETTLE: begin
               if (cnt_ff == '0) begin
                  cnt_ff   <= CNT_W'(STEP_CYC - 1);
                  state_ff <= SQ_STEP;
               end else begin
                  cnt_ff <= cnt_ff - 1'b1;
               end
            end
            SQ_STEP: begin
               if (cnt_ff != '0) begin
                  cnt_ff <= cnt_ff - 1'b1;
               end else begin
                  snap_ff <= filt_ff;
                  if (type_ff != TYPE_D && filt_ff != expect6(type_ff, seqNum_ff)) begin
                     err_ff   <= 1'b1;
                     auto_ff  <= 1'b0;
                     state_ff <= SQ_IDLE;
                  end else if (seqNum_ff == LAST_STEP) begin
                     auto_ff  <= 1'b0;
                     state_ff <= SQ_IDLE;
                  end else begin
                     seqNum_ff <= seqNum_ff + 3'h1;
                     cnt_ff    <= CNT_W'(STEP_CYC - 1);
                  end
               end
            end
            default: state_ff <= SQ_IDLE;
         endcase
      end
   end

   // pin outputs
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         gateOut_ff  <= 6'h00;
         relayDrv_ff <= RELAY_RST;
         midv_ff     <= 3'h0;
         vdsDetEn_ff <= 1'b1;
         vdsFault_ff <= 1'b0;
      end else begin
         gateOut_ff  <= (auto_ff ? drive : gateIn) & permit;
         relayDrv_ff <= relay_ff;
         midv_ff     <= auto_ff ? 3'h7 : (manualAct ? midon_ff : 3'h0);
         vdsDetEn_ff <= !inspect;
         vdsFault_ff <= !inspect && (|filt_ff);
      end
   end

   // register reads, answered one cycle later
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rvalid_ff <= 1'b0;
         rdata_ff  <= 16'h0000;
      end else begin
         rvalid_ff <= lnk.rd;
         rdata_ff  <= 16'h0000;
         if (lnk.rd) begin
            unique case (lnk.addr)
               REG_CNT1: rdata_ff <= {8'h00, view_ff, midon_ff, type_ff, 1'b0, manual_ff};
               REG_CNT2: rdata_ff <= {15'h0000, unlock_ff};
               REG_RELAY: rdata_ff <= {14'h0000, relay_ff};
               REG_PAT: rdata_ff <= {10'h000, pat_ff};
               REG_RES: rdata_ff <= {4'h0, psi_spread(view_ff ? filt_ff : snap_ff)};
               REG_SEQ: rdata_ff <= {9'h000, seqNum_ff, 2'h0, err_ff, auto_ff};
               default: rdata_ff <= 16'h0000;
            endcase
         end
      end
   end

   assign lnk.rdata  = rdata_ff;
   assign lnk.rvalid = rvalid_ff;
   assign gateOut    = gateOut_ff;
   assign relayDrv   = relayDrv_ff;
   assign midvResOnU = midv_ff[2];
   assign midvResOnV = midv_ff[1];
   assign midvResOnW = midv_ff[0];
   assign vdsDetEn   = vdsDetEn_ff;
   assign vdsFault   = vdsFault_ff;
endmodule // psi_dev_end
`default_nettype wire

// file: psi_chk.sv
/* assertion checker for the link between the two ends and device pins
   assumes one sys_clk domain and a synchronous active-high rst */
`timescale 1ns/10ps
`default_nettype none
module psi_chk
   import psi_pkg::*;
(
   input wire logic        sys_clk,
   input wire logic        rst,
   input wire logic        wr,
   input wire logic        rd,
   input wire logic [3:0]  addr,
   input wire logic [15:0] wdata,
   input wire logic [15:0] rdata,
   input wire logic        rvalid,
   input wire logic [5:0]  gateIn,
   input wire logic [2:0]  gateEn,
   input wire logic [5:0]  gateOut,
   input wire logic [1:0]  relayDrv,
   input wire logic        midvResOnU,
   input wire logic        midvResOnV,
   input wire logic        midvResOnW,
   input wire logic        vdsDetEn,
   input wire logic        vdsFault
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   sequence calm;
      $stable(gateIn) && gateEn == 3'h7 && vdsDetEn && !vdsFault;
   endsequence
   sequence autoSeen;
      rvalid && $past(addr) == REG_SEQ && rdata[SQ_AUTO];
   endsequence
   logic relayWr;
   assign relayWr = wr && addr == REG_RELAY;
   property permitOff(i);
      !gateEn[i] [*3] |-> gateOut[2*i+1 -: 2] == 2'b00;
   endproperty
   chk_link_answer: assert property (rd |=> rvalid)
      else $error("link read not answered");
   chk_relay_cause: assert property (!$stable(relayDrv) |-> $past(relayWr, 2) || $past(relayWr, 3))
      else $error("relay moved without relay write");
   chk_permit_u: assert property (permitOff(2))
      else $error("phase u driven without permit");
   chk_permit_v: assert property (permitOff(1))
      else $error("phase v driven without permit");
   chk_permit_w: assert property (permitOff(0))
      else $error("phase w driven without permit");
   chk_gate_follow: assert property (calm [*3] |-> gateOut == gateIn)
      else $error("gates not following inputs");
   chk_auto_res: assert property (autoSeen |-> ##[0:2] (midvResOnU && midvResOnV && midvResOnW))
      else $error("resistors off during sequence");
   chk_res_nodet: assert property ((midvResOnU || midvResOnV || midvResOnW) [*2] |-> !vdsDetEn)
      else $error("detection valid with resistors on");
endmodule // psi_chk
`default_nettype wire

// file: power_switch_inspection_mode_ctrl_tb_top.sv
/* bench for host and device ends joined by the link
   assumes 200 MHz sys_clk and software access over AXI4-Lite */
`timescale 1ns/10ps
`default_nettype none
module power_switch_inspection_mode_ctrl_tb_top import psi_pkg::*;;
   logic sys_clk = 1'b0, rst = 1'b1, noting = 1'b0;
   logic [5:0] gateIn = 6'h00, vdsCmp = 6'h00, gateOut, flt = 6'h00;
   logic [2:0] gateEn = 3'h7;
   logic [1:0] relayDrv, s_axi_bresp, s_axi_rresp;
   logic midvResOnU, midvResOnV, midvResOnW, vdsDetEn, vdsFault, irq;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d, v;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [67:0] q[$];
   int miscompares = 0, checks = 0, sd = 66514, i;
   psi_link_if psi_link_if_inst ();
   psi_dev_end psi_dev_end_inst (.sys_clk, .rst, .lnk(psi_link_if_inst), .gateIn, .gateEn, .vdsCmp,
      .gateOut, .relayDrv, .midvResOnU, .midvResOnV, .midvResOnW, .vdsDetEn, .vdsFault);
   psi_host_end psi_host_end_inst (.sys_clk, .rst, .lnk(psi_link_if_inst), .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .irq);
   psi_chk psi_chk_inst (.sys_clk, .rst, .wr(psi_link_if_inst.wr), .rd(psi_link_if_inst.rd),
      .addr(psi_link_if_inst.addr), .wdata(psi_link_if_inst.wdata), .rdata(psi_link_if_inst.rdata),
      .rvalid(psi_link_if_inst.rvalid), .gateIn, .gateEn, .gateOut, .relayDrv, .midvResOnU, .midvResOnV,
      .midvResOnW, .vdsDetEn, .vdsFault);
   initial begin
      forever #2.5 sys_clk = ~sys_clk;
   end
   // plant: a comparator reads high while its switch is off
   always @(posedge sys_clk) vdsCmp <= ~gateOut ^ flt;
   task automatic ck(input string nm, input logic [33:0] seen, input logic [33:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic close_out;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic hung;
      miscompares++;
      close_out;
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] dw);
      int n;
      s_axi_awaddr <= a;
      s_axi_wdata <= dw;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge sys_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 1'b0;
      if (n == 50) hung;
      ck("bresp", 34'(s_axi_bresp), 34'h0);
      wt(1);
   endtask
   task automatic axr(input logic [7:0] a, input logic note, input logic [33:0] e, input logic [33:0] m);
      int n;
      if (note) q.push_back({e & m, m});
      noting <= note;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge sys_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      d = s_axi_rdata;
      s_axi_rready <= 1'b0;
      noting <= 1'b0;
      if (n == 50) hung;
      wt(1);
   endtask
   task automatic idle;
      int n;
      wt(20);
      for (n = 0; n < 3000; n++) begin
         axr(H_STAT, 1'b0, 34'h0, 34'h0);
         if (!d[SQ_AUTO]) break;
      end
      if (n == 3000) hung;
   endtask
   always @(posedge sys_clk) begin
      logic [67:0] n;
      if (s_axi_rvalid && s_axi_rready && noting && q.size() > 0) begin
         n = q.pop_front();
         ck("axi read", {s_axi_rresp, s_axi_rdata} & n[33:0], n[67:34]);
      end
   end
   initial begin
      wt(2);
      rst <= 1'b0;
      wt(2);
      axr(8'h1c, 1'b1, {2'b10, 32'h0}, '1);
      axw(H_IRQ_MASK, 32'h3);
      axr(H_IRQ_MASK, 1'b1, 34'h3, 34'h3);
      v = $random(sd);
      axw(H_RELAY, {30'h0, v[1:0]});
      wt(10);
      ck("relay", 34'(relayDrv), 34'(v[1:0]));
      for (i = 0; i < 4; i++) begin
         gateIn <= 6'($random(sd));
         wt(6);
         ck("gates", 34'(gateOut), 34'(gateIn));
      end
      gateEn <= 3'h3;
      wt(5);
      ck("permit", 34'(gateOut[5:4]), 34'h0);
      gateEn <= 3'h7;
      $display("test normal finished");
      for (i = 1; i < 8; i++) begin
         axw(H_CMD, 32'h101 | 32'(i << 4));
         wt(10);
         ck("resistors", 34'({midvResOnU, midvResOnV, midvResOnW}), 34'(i));
         ck("detect", 34'(vdsDetEn), 34'h0);
         ck("gates", 34'(gateOut), 34'(gateIn));
      end
      gateIn <= 6'h00;
      axw(H_CMD, 32'h1f1);
      wt(10);
      axr(H_RES, 1'b1, 34'h555, 34'hfff);
      axw(H_CMD, 32'h0);
      wt(10);
      ck("resistors", 34'({midvResOnU, midvResOnV, midvResOnW}), 34'h0);
      ck("detect", 34'(vdsDetEn), 34'h1);
      axw(H_CMD, 32'h80);
      wt(10);
      ck("fault", 34'(vdsFault), 34'h0);
      flt <= 6'h20;
      gateIn <= 6'h20;
      wt(10);
      ck("fault", 34'(vdsFault), 34'h1);
      axr(H_RES, 1'b1, 34'h400, 34'hfff);
      flt <= 6'h00;
      $display("test manual finished");
      v = $random(sd);
      axw(H_PAT, {26'h0, v[5:0]});
      gateIn <= ~v[5:0];
      axw(H_CMD, 32'h10e);
      wt(2500);
      ck("gates", 34'(gateOut), 34'(v[5:0]));
      ck("resistors", 34'({midvResOnU, midvResOnV, midvResOnW}), 34'h7);
      idle;
      axr(H_STAT, 1'b1, 34'h0, 34'h3);
      ck("irq", 34'(irq), 34'h1);
      axr(H_IRQ_STAT, 1'b1, 34'h1, 34'h1);
      wt(3);
      ck("irq", 34'(irq), 34'h0);
      axw(H_CMD, 32'h103);
      wt(100);
      ck("resistors", 34'({midvResOnU, midvResOnV, midvResOnW}), 34'h7);
      idle;
      axr(H_STAT, 1'b1, 34'h60, 34'h73);
      axw(H_CMD, 32'h106);
      idle;
      axr(H_STAT, 1'b1, 34'h12, 34'h73);
      axr(H_IRQ_STAT, 1'b1, 34'h3, 34'h3);
      axw(H_CMD, 32'h102);
      wt(100);
      axw(H_CMD, 32'h0);
      wt(10);
      ck("resistors", 34'({midvResOnU, midvResOnV, midvResOnW}), 34'h0);
      axr(H_STAT, 1'b1, 34'h0, 34'h3);
      $display("test automatic finished");
      close_out;
   end
endmodule // power_switch_inspection_mode_ctrl_tb_top
`default_nettype wire
